/* sim/spiwp_peer.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Serial slave peer, mode 0, MSB first
// ----------------------------------------
module spiwp_peer (
   // Link
   input  wire logic        sck_i,
   input  wire logic        ss_n_i,
   input  wire logic        mosi_i,
   output logic             miso_o,
   // Data
   input  wire logic [15:0] reply_i,
   output logic [15:0]      got_o,
   output logic [4:0]       rises_o
);
   logic [15:0] sh_q;
   initial begin
      miso_o = 1'b0;
      got_o = 16'h0000;
      rises_o = 5'h00;
   end
   // Load reply on select
   always @(negedge ss_n_i) begin
      sh_q = reply_i;
      rises_o = 5'h00;
      miso_o = reply_i[15];
   end
   // Released line shows inverse
   always @(posedge ss_n_i) miso_o = ~miso_o;
   always @(posedge sck_i) if (!ss_n_i) begin
      got_o = {got_o[14:0], mosi_i};
      rises_o = rises_o + 5'h01;
   end
   always @(negedge sck_i) if (!ss_n_i) begin
      sh_q = {sh_q[14:0], 1'b0};
      miso_o = sh_q[15];
   end
endmodule

/* sim/test_spi_width_and_pin_config.sv */
`timescale 1ns/1ps
`include "spiwp_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_spi_width_and_pin_config;
   import spiwp_pkg::*;
   typedef struct packed {logic [7:0] ctrl; logic [7:0] cfg; logic [7:0] exp; logic [2:0] oe;} spiwp_row_s;
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_CFG  = 6'h04;
   localparam logic [5:0] A_ST   = 6'h0C;
   localparam logic [5:0] A_HI   = 6'h10;
   localparam logic [5:0] A_LO   = 6'h14;
   localparam logic [5:0] A_MSK  = 6'h20;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic        wait_mode_i = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0, ss_ext = 1'b1;
   logic [5:0]  adr_i = 6'h00;
   logic [3:0]  sel_i = 4'h1;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic        ack_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   logic        ss_o, ss_oe_o, irq_o, peer_miso;
   logic [15:0] reply = 16'h0000, got;
   logic [4:0]  rises, n0;
   logic [7:0]  r, cap;
   int          fail_count = 0, checks_done = 0, cyc_cnt = 0;
   wire logic   sck_w  = sck_oe_o ? sck_o : tb_sck;
   wire logic   mosi_w = mosi_oe_o ? mosi_o : tb_mosi;
   wire logic   miso_w = miso_oe_o ? miso_o : peer_miso;
   wire logic   ss_w   = ss_oe_o ? ss_o : ss_ext;
   spiwp_row_s  rows [8] = '{'{8'h12, 8'h10, 8'h10, 3'b101}, '{8'h12, 8'h11, 8'h11, 3'b001},
      '{8'h12, 8'hFF, 8'h5B, 3'b101}, '{8'h12, 8'hA4, 8'h00, 3'b100},
      '{8'h12, 8'h18, 8'h18, 3'b101}, '{8'h10, 8'h10, 8'h10, 3'b100},
      '{8'h00, 8'h11, 8'h11, 3'b000}, '{8'h00, 8'h10, 8'h10, 3'b000}};
   logic [16:0] ab [6] = '{{8'h10, 8'h50, 1'b1}, {8'h10, 8'h00, 1'b1}, {8'h10, 8'h11, 1'b1},
      {8'h11, 8'h19, 1'b1}, {8'h10, 8'h12, 1'b0}, {8'h10, 8'h18, 1'b0}};

   spiwp_top DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .wait_mode_i, .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o,
      .mosi_oe_o, .miso_i(miso_w), .miso_o, .miso_oe_o, .ss_i(ss_w), .ss_o, .ss_oe_o, .irq_o);
   spiwp_peer peer (.sck_i(sck_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .miso_o(peer_miso),
      .reply_i(reply), .got_o(got), .rises_o(rises));

   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 30000) begin
         fail_count++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic clks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      r = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a);
      wb(1'b0, a, 8'h00);
   endtask
   task automatic wait_done();
      do begin
         rd(A_ST);
      end while (r[`SPIWP_ST_DONE] !== 1'b1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clks(2);
      rst_i <= 1'b0;
      clks(3);
      `CHK("ss idle", 2'b10, {ss_o, ss_oe_o})
      rd(A_CFG);
      `CHK("cfg reset", 8'h00, r)
      for (int i = 0; i < 8; i++) begin
         wr(A_CTRL, rows[i].ctrl);
         wr(A_CFG, rows[i].cfg);
         rd(A_CFG);
         `CHK("cfg read", rows[i].exp, r)
         clks(3);
         `CHK("pin enables", rows[i].oe, {mosi_oe_o, miso_oe_o, ss_oe_o})
      end
      wr(6'h3C, 8'hFF);
      rd(6'h3C);
      `CHK("unmapped", 8'h00, r)
      $display("test table ended");
      wr(A_CTRL, 8'h12);
      wr(A_MSK, 8'h80);
      wr(A_CFG, 8'h10);
      reply <= 16'h3C00;
      wr(A_LO, 8'hA5);
      clks(10);
      `CHK("ss low", 1'b0, ss_o)
      wait_done();
      `CHK("irq", 1'b1, irq_o)
      `CHK("sent 8", 13'h08A5, {rises, got[7:0]})
      rd(A_LO);
      `CHK("rx lo", 8'h3C, r)
      rd(A_HI);
      `CHK("rx hi", 8'h00, r)
      wr(A_ST, 8'h80);
      wr(A_MSK, 8'h00);
      clks(2);
      `CHK("irq clr", 1'b0, irq_o)
      wr(A_CFG, 8'h50);
      reply <= 16'hBEEF;
      wr(A_HI, 8'h12);
      wr(A_LO, 8'h34);
      wait_done();
      `CHK("sent 16", 21'h101234, {rises, got})
      rd(A_HI);
      `CHK("rx hi", 8'hBE, r)
      rd(A_LO);
      `CHK("rx lo", 8'hEF, r)
      `CHK("irq masked", 1'b0, irq_o)
      $display("test frames ended");
      for (int i = 0; i < 6; i++) begin
         wr(A_ST, 8'h94);
         wr(A_CFG, ab[i][16:9]);
         wr(A_LO, 8'h5A);
         clks(20);
         wr(A_CFG, ab[i][8:1]);
         clks(4);
         rd(A_ST);
         `CHK("abort", {ab[i][0], ~ab[i][0]}, {r[2], r[0]})
         if (!ab[i][0]) wait_done();
      end
      wr(A_ST, 8'h94);
      wr(A_CFG, 8'h10);
      wr(A_LO, 8'h5A);
      clks(20);
      wr(A_CTRL, 8'h00);
      clks(4);
      rd(A_ST);
      `CHK("role idle", 2'b00, {r[0], sck_oe_o})
      $display("test aborts ended");
      wr(A_CTRL, 8'h12);
      wr(A_CFG, 8'h12);
      wr(A_LO, 8'h81);
      clks(12);
      wait_mode_i <= 1'b1;
      clks(2);
      n0 = rises;
      clks(40);
      `CHK("sck frozen", n0, rises)
      wait_mode_i <= 1'b0;
      wait_done();
      `CHK("resumed", 5'h08, rises)
      wr(A_ST, 8'h94);
      wr(A_CFG, 8'h10);
      wait_mode_i <= 1'b1;
      wr(A_LO, 8'h81);
      wait_done();
      `CHK("sck runs", 5'h08, rises)
      wait_mode_i <= 1'b0;
      $display("test wait ended");
      wr(A_ST, 8'h94);
      wr(A_CTRL, 8'h10);
      wr(A_MSK, 8'h10);
      ss_ext <= 1'b0;
      clks(6);
      rd(A_ST);
      `CHK("fault", 2'b11, {r[4], irq_o})
      ss_ext <= 1'b1;
      clks(3);
      wr(A_ST, 8'h10);
      clks(2);
      `CHK("fault clr", 1'b0, irq_o)
      wr(A_CFG, 8'h00);
      ss_ext <= 1'b0;
      clks(6);
      rd(A_ST);
      `CHK("no fault", 1'b0, r[4])
      ss_ext <= 1'b1;
      $display("test fault ended");
      wr(A_CTRL, 8'h00);
      wr(A_LO, 8'hC3);
      ss_ext <= 1'b0;
      clks(8);
      for (int i = 7; i >= 0; i--) begin
         tb_mosi <= 1'(8'h5A >> i);
         clks(4);
         tb_sck <= 1'b1;
         clks(1);
         cap = {cap[6:0], miso_w};
         clks(3);
         tb_sck <= 1'b0;
      end
      `CHK("slave oe", 1'b1, miso_oe_o)
      clks(8);
      ss_ext <= 1'b1;
      clks(4);
      `CHK("slave out", 8'hC3, cap)
      rd(A_LO);
      `CHK("slave in", 8'h5A, r)
      $display("test slave ended");
      complete_run();
   end
endmodule

/* src/spiwp_consts.svh */
`ifndef SPIWP_CONSTS_SVH
`define SPIWP_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SPIWP_IDX_CTRL      4'h0
`define SPIWP_IDX_CFG       4'h1
`define SPIWP_IDX_STAT      4'h3
`define SPIWP_IDX_DATA_HI   4'h4
`define SPIWP_IDX_DATA_LO   4'h5
`define SPIWP_IDX_MASK      4'h8

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define SPIWP_CTRL_MASTER   4
`define SPIWP_CTRL_SELECT_OUTPUT_ENABLE     1
`define SPIWP_CTRL_MASK     8'h12
`define SPIWP_CFG_MASK      8'h5B
`define SPIWP_ST_DONE       7
`define SPIWP_ST_FAULT      4
`define SPIWP_ST_ABORT      2
`define SPIWP_ST_BUSY       0
`define SPIWP_ST_MASK       8'h94

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPIWP_CFG_RST       8'h00
`define SPIWP_CTRL_RST      8'h00
`define SPIWP_PINS_RST      4'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPIWP_CLK_NS        100
`define SPIWP_HALF_NS       400
`define SPIWP_HALF_CYC      ((`SPIWP_HALF_NS) / (`SPIWP_CLK_NS))

`endif

/* src/spiwp_pkg.sv */
package spiwp_pkg;

   // ----------------------------------------------------------------
   // Synchronised pin levels
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss;
   } spiwp_pins_s;

   // ----------------------------------------------------------------
   // Width and pin control register layout
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rsv7;
      logic transfer_width_select;
      logic rsv5;
      logic mode_fault_enable;
      logic bidir_output_enable;
      logic rsv2;
      logic wait_mode_clock_stop;
      logic pin_control_bidir;
   } spiwp_cfg_s;

   // ----------------------------------------------------------------
   // Shifter states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPIWP_SH_IDLE = 2'b01,
      SPIWP_SH_RUN  = 2'b10
   } spiwp_sh_e;

endpackage

/* src/spiwp_shifter.sv */
`timescale 1ns/1ps
`include "spiwp_consts.svh"

module spiwp_shifter
   import spiwp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Control
   input  wire logic        start_i,
   input  wire logic        abort_i,
   input  wire logic        stall_i,
   input  wire logic        master_i,
   input  wire logic        wide_i,
   input  wire logic        sel_i,
   // Link
   input  wire logic        sck_rise_i,
   input  wire logic        sck_fall_i,
   input  wire logic        din_i,
   output logic             sck_o,
   output logic             dout_o,
   // Data
   input  wire logic [15:0] tx_i,
   output logic [15:0]      rx_o,
   output logic             busy_o,
   output logic             done_o
);

   spiwp_sh_e   state_q;
   logic [15:0] sh_q;
   logic [3:0]  cnt_q;
   logic [2:0]  div_q;
   logic        in_q;
   logic        tick;
   logic        rise;
   logic        fall;
   logic        last;

   assign tick   = master_i && !stall_i && div_q == 3'(`SPIWP_HALF_CYC - 1);
   assign rise   = master_i ? (tick && !sck_o) : sck_rise_i;
   assign fall   = master_i ? (tick && sck_o) : sck_fall_i;
   assign last   = cnt_q == (wide_i ? 4'hF : 4'h7);
   assign busy_o = state_q == SPIWP_SH_RUN;
   assign dout_o = sh_q[15];

   // ----------------------------------------------------------------
   // Serial clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !busy_o || tick) begin
         div_q <= 3'h0;
      end else if (!stall_i) begin
         div_q <= div_q + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Frame shifter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= SPIWP_SH_IDLE;
         sh_q    <= 16'h0000;
         cnt_q   <= 4'h0;
         sck_o   <= 1'b0;
         in_q    <= 1'b0;
         done_o  <= 1'b0;
         rx_o    <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         unique case (state_q)
            SPIWP_SH_IDLE: begin
               if (!abort_i && (master_i ? start_i : sel_i)) begin
                  state_q <= SPIWP_SH_RUN;
                  sh_q    <= wide_i ? tx_i : {tx_i[7:0], 8'h00};
                  cnt_q   <= 4'h0;
                  sck_o   <= 1'b0;
               end
            end
            SPIWP_SH_RUN: begin
               if (abort_i || (!master_i && !sel_i)) begin
                  state_q <= SPIWP_SH_IDLE;
                  sck_o   <= 1'b0;
               end else begin
                  if (tick) begin
                     sck_o <= !sck_o;
                  end
                  if (rise) begin
                     in_q <= din_i;
                  end
                  if (fall) begin
                     sh_q  <= {sh_q[14:0], in_q};
                     cnt_q <= cnt_q + 4'h1;
                     if (last) begin
                        state_q <= SPIWP_SH_IDLE;
                        done_o  <= 1'b1;
                        rx_o    <= wide_i ? {sh_q[14:0], in_q} : {8'h00, sh_q[6:0], in_q};
                     end
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_frame_width: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(done_o) |-> $past(cnt_q) == ($past(wide_i) ? 4'hF : 4'h7))
      else $error("frame length does not match width");

endmodule

/* src/spiwp_sync.sv */
`timescale 1ns/1ps
`include "spiwp_consts.svh"

module spiwp_sync
   import spiwp_pkg::*;
(
   // Clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // Pin levels
   input  spiwp_pins_s d_i,
   output spiwp_pins_s q_o
);

   spiwp_pins_s meta_q;

   // ----------------------------------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= spiwp_pins_s'(`SPIWP_PINS_RST);
         q_o    <= spiwp_pins_s'(`SPIWP_PINS_RST);
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule

/* src/spiwp_top.sv */
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "spiwp_consts.svh"

// How it works
// - Width bit clear gives 8-bit frames through the low data byte only.
// - Width bit set joins high and low data bytes into 16-bit frames.
// - As master, changing width, fault enable or pin control aborts to idle.
// - As bidirectional master, changing output enable aborts to idle.
// - Master with fault enable clear leaves the select pin untouched.
// - Master with fault enable set and select output clear uses the select pin with fault detection.
// - As slave the select pin is only an input.
// - In bidirectional mode output enable gates MOSI as master, MISO as slave.
// - Clock stop bit halts serial clock generation during wait mode.
// - Pin control clear is two data wires, set is one shared wire.
// - Normal pins: master drives MOSI, slave drives MISO, enable ignored.
// - Bidirectional master uses MOSI only, output when enabled.
// - Bidirectional slave uses MISO only, output when enabled.
// - Register readable and writable anytime, reserved bits stay zero.
// - Master with fault enable drives select out, or senses faults.
// - Changing master or slave role forces idle.
module spiwp_top
   import spiwp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [5:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Chip power state
   input  wire logic        wait_mode_i,
   // Serial pins
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   input  wire logic        ss_i,
   output logic             ss_o,
   output logic             ss_oe_o,
   // Interrupt
   output logic             irq_o
);

   spiwp_cfg_s  cfg_q;
   spiwp_cfg_s  cfg_new;
   spiwp_pins_s pins_raw;
   spiwp_pins_s pins_s;
   logic        master_q;
   logic        select_output_enable_q;
   logic [15:0] tx_q;
   logic [7:0]  int_q;
   logic [7:0]  int_set;
   logic [7:0]  mask_q;
   logic        sck_prev_q;
   logic [3:0]  idx;
   logic        acc;
   logic        wr;
   logic        abort_d;
   logic        fault;
   logic        slave_sel;
   logic        stall;
   logic        din;
   logic        busy;
   logic        done;
   logic        sh_sck;
   logic        sh_dout;
   logic [15:0] rx;
   logic [7:0]  rd_d;

   assign idx      = adr_i[5:2];
   assign acc      = cyc_i && stb_i && !ack_o;
   assign wr       = acc && we_i && sel_i[0];
   assign cfg_new  = spiwp_cfg_s'(dat_i[7:0] & `SPIWP_CFG_MASK);
   assign pins_raw = '{sck: sck_i, mosi: mosi_i, miso: miso_i, ss: ss_i};

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   spiwp_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pins_raw),
      .q_o   (pins_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= pins_s.sck;
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   assign slave_sel = !master_q && !pins_s.ss;
   assign fault     = master_q && cfg_q.mode_fault_enable && !select_output_enable_q && !pins_s.ss;
   assign stall     = wait_mode_i && cfg_q.wait_mode_clock_stop;

   always_comb begin
      if (master_q) begin
         din = cfg_q.pin_control_bidir ? pins_s.mosi : pins_s.miso;
      end else begin
         din = cfg_q.pin_control_bidir ? pins_s.miso : pins_s.mosi;
      end
   end

   always_comb begin
      abort_d = fault;
      if (wr && idx == `SPIWP_IDX_CFG && master_q) begin
         if (cfg_new.transfer_width_select != cfg_q.transfer_width_select ||
             cfg_new.mode_fault_enable != cfg_q.mode_fault_enable ||
             cfg_new.pin_control_bidir != cfg_q.pin_control_bidir) begin
            abort_d = 1'b1;
         end
         if (cfg_q.pin_control_bidir &&
             cfg_new.bidir_output_enable != cfg_q.bidir_output_enable) begin
            abort_d = 1'b1;
         end
      end
      if (wr && idx == `SPIWP_IDX_CTRL) begin
         if (dat_i[`SPIWP_CTRL_MASTER] != master_q) begin
            abort_d = 1'b1;
         end
         if (master_q && dat_i[`SPIWP_CTRL_SELECT_OUTPUT_ENABLE] != select_output_enable_q) begin
            abort_d = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   spiwp_shifter u_shift (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .start_i    (wr && idx == `SPIWP_IDX_DATA_LO && master_q),
      .abort_i    (abort_d),
      .stall_i    (stall),
      .master_i   (master_q),
      .wide_i     (cfg_q.transfer_width_select),
      .sel_i      (slave_sel),
      .sck_rise_i (pins_s.sck && !sck_prev_q),
      .sck_fall_i (!pins_s.sck && sck_prev_q),
      .din_i      (din),
      .sck_o      (sh_sck),
      .dout_o     (sh_dout),
      .tx_i       (wr && idx == `SPIWP_IDX_DATA_LO ? {tx_q[15:8], dat_i[7:0]} : tx_q),
      .rx_o       (rx),
      .busy_o     (busy),
      .done_o     (done)
   );

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= spiwp_cfg_s'(`SPIWP_CFG_RST);
      end else if (wr && idx == `SPIWP_IDX_CFG) begin
         cfg_q <= cfg_new;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_q <= 1'(`SPIWP_CTRL_RST >> `SPIWP_CTRL_MASTER);
         select_output_enable_q   <= 1'b0;
      end else if (wr && idx == `SPIWP_IDX_CTRL) begin
         master_q <= dat_i[`SPIWP_CTRL_MASTER];
         select_output_enable_q   <= dat_i[`SPIWP_CTRL_SELECT_OUTPUT_ENABLE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q <= 16'h0000;
      end else if (wr && idx == `SPIWP_IDX_DATA_HI) begin
         tx_q[15:8] <= dat_i[7:0];
      end else if (wr && idx == `SPIWP_IDX_DATA_LO) begin
         tx_q[7:0] <= dat_i[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   always_comb begin
      int_set                  = 8'h00;
      int_set[`SPIWP_ST_DONE]  = done;
      int_set[`SPIWP_ST_FAULT] = fault;
      int_set[`SPIWP_ST_ABORT] = abort_d && busy;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_q <= 8'h00;
      end else if (wr && idx == `SPIWP_IDX_STAT) begin
         int_q <= (int_q & ~dat_i[7:0]) | int_set;
      end else begin
         int_q <= int_q | int_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= 8'h00;
      end else if (wr && idx == `SPIWP_IDX_MASK) begin
         mask_q <= dat_i[7:0] & `SPIWP_ST_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(int_q & mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Wishbone answer
   // ----------------------------------------------------------------
   always_comb begin
      unique case (idx)
         `SPIWP_IDX_CTRL:    rd_d = {3'h0, master_q, 2'h0, select_output_enable_q, 1'b0};
         `SPIWP_IDX_CFG:     rd_d = cfg_q;
         `SPIWP_IDX_STAT:    rd_d = int_q | {7'h00, busy};
         `SPIWP_IDX_DATA_HI: rd_d = rx[15:8];
         `SPIWP_IDX_DATA_LO: rd_d = rx[7:0];
         `SPIWP_IDX_MASK:    rd_d = mask_q;
         default:            rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= acc;
         dat_o <= acc ? {24'h000000, rd_d} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_o     <= 1'b0;
         sck_oe_o  <= 1'b0;
         mosi_o    <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
         ss_o      <= 1'b1;
         ss_oe_o   <= 1'b0;
      end else begin
         sck_o     <= sh_sck;
         sck_oe_o  <= master_q;
         mosi_o    <= sh_dout;
         miso_o    <= sh_dout;
         mosi_oe_o <= master_q &&
                      (!cfg_q.pin_control_bidir || cfg_q.bidir_output_enable);
         miso_oe_o <= slave_sel &&
                      (!cfg_q.pin_control_bidir || cfg_q.bidir_output_enable);
         ss_o      <= !busy;
         ss_oe_o   <= master_q && cfg_q.mode_fault_enable && select_output_enable_q;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence cfg_flip_s;
      wr && idx == `SPIWP_IDX_CFG && master_q &&
      cfg_new.transfer_width_select != cfg_q.transfer_width_select;
   endsequence

   sequence stalled_s;
      stall && master_q && busy [*2];
   endsequence

   chk_abort_idle: assert property (cfg_flip_s |=> !busy)
      else $error("width change did not stop the frame");
   chk_bidir_flip: assert property (wr && idx == `SPIWP_IDX_CFG && master_q &&
      cfg_q.pin_control_bidir && cfg_new.bidir_output_enable != cfg_q.bidir_output_enable
      |=> !busy)
      else $error("output enable change did not stop the frame");
   chk_role_idle: assert property (wr && idx == `SPIWP_IDX_CTRL &&
      dat_i[`SPIWP_CTRL_MASTER] != master_q |=> !busy ##1 !sck_o)
      else $error("role change did not force idle");
   chk_select_unused: assert property (master_q && !cfg_q.mode_fault_enable |=> !ss_oe_o)
      else $error("select pin driven with fault enable clear");
   chk_select_input: assert property (!master_q |=> !ss_oe_o)
      else $error("slave drives select pin");
   chk_select_output: assert property (
      master_q && cfg_q.mode_fault_enable && select_output_enable_q |=> ss_oe_o)
      else $error("select output not enabled");
   chk_fault_flag: assert property (fault |=> int_q[`SPIWP_ST_FAULT] && !busy)
      else $error("mode fault not caught");
   chk_wait_stop: assert property (stalled_s |=> $stable(sck_o))
      else $error("serial clock moved in wait mode");
   chk_normal_pins: assert property (master_q && !cfg_q.pin_control_bidir
      |=> mosi_oe_o && !miso_oe_o)
      else $error("normal master pin drive wrong");
   chk_bidir_master: assert property (master_q && cfg_q.pin_control_bidir
      |=> !miso_oe_o && mosi_oe_o == $past(cfg_q.bidir_output_enable))
      else $error("bidirectional master pin drive wrong");
   chk_bidir_slave: assert property (!master_q && cfg_q.pin_control_bidir
      |=> !mosi_oe_o && miso_oe_o == ($past(slave_sel) && $past(cfg_q.bidir_output_enable)))
      else $error("bidirectional slave pin drive wrong");
   chk_reserved_zero: assert property ((cfg_q & ~`SPIWP_CFG_MASK) == 8'h00)
      else $error("reserved bit set");

endmodule
